// *** rtl/totalizer_defs.svh ***
`ifndef TOTALIZER_DEFS_SVH
`define TOTALIZER_DEFS_SVH
`define CNT_W 26
`define CNT_MAX 26'h3FFFFFF
`define PORT_W 8
`define DAC_W 16
`define CLK_HZ 40000000
`define PULSE_MAX_HZ 100000
// Cycles in the shortest half period of the pulse input (rounded down)
`define PULSE_HALF_CYC ((`CLK_HZ / `PULSE_MAX_HZ) / 2)
`endif

// *** rtl/totalizer_pkg.sv ***
`default_nettype none
package totalizer_pkg;
  typedef enum logic [1:0] {
    RD_NONE = 2'b00,
    RD_PORT = 2'b01,
    RD_WORD = 2'b10,
    RD_COUNT = 2'b11
  } read_kind_e;
endpackage : totalizer_pkg
`default_nettype wire

// *** rtl/sync2.sv ***
`include "totalizer_defs.svh"
`default_nettype none
module sync2 #(
  parameter int W = 3
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  if (W < 1) begin : g_bad_w
    $error("Synchroniser width must be at least one");
  end
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;

  always_comb begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;
endmodule : sync2
`default_nettype wire

// *** rtl/gated_totalizer_with_dio.sv ***
`include "totalizer_defs.svh"
`default_nettype none
module gated_totalizer_with_dio
  import totalizer_pkg::*;
#(
  parameter int CNT_W = `CNT_W,
  parameter int PORT_W = `PORT_W,
  parameter int DAC_W = `DAC_W
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Field side
  input wire logic pulse_i,
  input wire logic gate_hi_i,
  input wire logic gate_lo_n_i,
  input wire logic [PORT_W-1:0] port0_pin_i,
  input wire logic [PORT_W-1:0] port1_pin_i,
  output logic [PORT_W-1:0] port0_pin_o,
  output logic [PORT_W-1:0] port0_pin_oe_o,
  output logic [PORT_W-1:0] port1_pin_o,
  output logic [PORT_W-1:0] port1_pin_oe_o,
  output logic [DAC_W-1:0] dac0_code_o,
  output logic [DAC_W-1:0] dac1_code_o,
  // Host side
  input wire logic count_falling_i,
  input wire logic count_clear_i,
  input wire logic [PORT_W-1:0] port0_drive_i,
  input wire logic [PORT_W-1:0] port1_drive_i,
  input wire logic dac0_wr_i,
  input wire logic dac1_wr_i,
  input wire logic [DAC_W-1:0] dac_code_i,
  input wire logic port0_in_scan_i,
  input wire logic port1_in_scan_i,
  input wire logic rd_req_i,
  input wire logic rd_remote_i,
  input wire logic [1:0] rd_kind_i,
  input wire logic rd_port_sel_i,
  output logic rd_valid_o,
  output logic rd_refused_o,
  output logic [CNT_W-1:0] rd_data_o,
  output logic [CNT_W-1:0] count_o
);
  // ==========================================================
  // Parameter check
  // The wrap assertion and the read packing assume these sizes
  if (CNT_W != `CNT_W || PORT_W != `PORT_W || DAC_W != `DAC_W) begin : g_bad_width
    $error("Widths must match the counter and port sizes");
  end

  // ==========================================================
  // Reset release and input synchronisers
  logic rst_a_ff;
  logic rst_n_ff;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  logic [2:0] sync_q;
  sync2 #(.W(3)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_ff),
    .d_i({pulse_i, gate_hi_i, gate_lo_n_i}),
    .q_o(sync_q)
  );
  logic pulse_s;
  logic gate_hi_s;
  logic gate_lo_n_s;
  assign pulse_s = sync_q[2];
  assign gate_hi_s = sync_q[1];
  assign gate_lo_n_s = sync_q[0];

  // ==========================================================
  // State
  typedef struct packed {
    logic pulse_d;
    logic [CNT_W-1:0] count;
    logic [PORT_W-1:0] p0_oe;
    logic [PORT_W-1:0] p1_oe;
    logic [DAC_W-1:0] dac0;
    logic [DAC_W-1:0] dac1;
    logic rd_valid;
    logic rd_refused;
    logic [CNT_W-1:0] rd_data;
  } core_s;
  core_s st_ff;
  core_s nxt_st;

  function automatic logic [CNT_W-1:0] widen(input logic [2*PORT_W-1:0] v);
    widen = {{(CNT_W-2*PORT_W){1'b0}}, v};
  endfunction : widen

  logic edge_hit;
  logic gates_open;
  always_comb begin
    nxt_st = st_ff;
    // Only the chosen edge qualifies; each edge is seen once at 40 MHz
    edge_hit = count_falling_i ? (st_ff.pulse_d & ~pulse_s)
                               : (~st_ff.pulse_d & pulse_s);
    gates_open = gate_hi_s & ~gate_lo_n_s;
    nxt_st.pulse_d = pulse_s;
    if (count_clear_i) begin
      nxt_st.count = '0;
    end else if (edge_hit && gates_open) begin
      // Natural 26-bit overflow wraps the max to zero
      nxt_st.count = st_ff.count + 1'b1;
    end
    // Open drain: a 0 bit pulls low, a 1 bit releases the pin
    nxt_st.p0_oe = ~port0_drive_i;
    nxt_st.p1_oe = ~port1_drive_i;
    if (dac0_wr_i) begin
      nxt_st.dac0 = dac_code_i;
    end
    if (dac1_wr_i) begin
      nxt_st.dac1 = dac_code_i;
    end
    nxt_st.rd_valid = 1'b0;
    nxt_st.rd_refused = 1'b0;
    if (rd_req_i) begin
      case (read_kind_e'(rd_kind_i))
        RD_PORT: begin
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data = widen({{PORT_W{1'b0}},
                                  rd_port_sel_i ? port1_pin_i : port0_pin_i});
        end
        RD_WORD: begin
          // Front panel never gets the word; remote only outside the scan list
          if (rd_remote_i && !port0_in_scan_i && !port1_in_scan_i) begin
            nxt_st.rd_valid = 1'b1;
            nxt_st.rd_data = widen({port1_pin_i, port0_pin_i});
          end else begin
            nxt_st.rd_refused = 1'b1;
          end
        end
        RD_COUNT: begin
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data = st_ff.count;
        end
        default: begin
          nxt_st.rd_refused = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_o = st_ff.count;
  assign port0_pin_o = '0;
  assign port1_pin_o = '0;
  assign port0_pin_oe_o = st_ff.p0_oe;
  assign port1_pin_oe_o = st_ff.p1_oe;
  assign dac0_code_o = st_ff.dac0;
  assign dac1_code_o = st_ff.dac1;
  assign rd_valid_o = st_ff.rd_valid;
  assign rd_refused_o = st_ff.rd_refused;
  assign rd_data_o = st_ff.rd_data;

  // ==========================================================
  // Assertions
  sequence s_qual_edge;
    edge_hit && gates_open && !count_clear_i;
  endsequence

  a_count_advance: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    s_qual_edge |=> count_o == $past(count_o) + 1'b1)
    else $error("Count did not advance on qualifying edge");
  a_count_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    s_qual_edge and (count_o == `CNT_MAX) |=> count_o == '0)
    else $error("Count did not wrap");
  a_gate_block: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (!count_clear_i && !(gate_hi_s && !gate_lo_n_s)) |=> $stable(count_o))
    else $error("Count moved while gated off");
  a_gate_hi_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (!gate_hi_s && !count_clear_i) |=> count_o == $past(count_o))
    else $error("Count moved with high gate low");
  a_gate_lo_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (gate_lo_n_s && !count_clear_i) |=> count_o == $past(count_o))
    else $error("Count moved with low gate high");
  a_edge_polarity: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (!count_clear_i && (pulse_s == count_falling_i)) |=> $stable(count_o))
    else $error("Wrong edge advanced count");
  a_word_refused: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (rd_req_i && rd_kind_i == RD_WORD && (port0_in_scan_i || port1_in_scan_i))
      |=> rd_refused_o && !rd_valid_o)
    else $error("Word read not refused");
  a_panel_word: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (rd_req_i && rd_kind_i == RD_WORD && !rd_remote_i) |=> !rd_valid_o)
    else $error("Front panel got word read");
  a_port_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (rd_req_i && rd_kind_i == RD_PORT) |=> rd_valid_o && rd_data_o[CNT_W-1:PORT_W] == '0)
    else $error("Port read wrong");
  a_dac_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    dac0_wr_i |=> dac0_code_o == $past(dac_code_i))
    else $error("DAC code not loaded");
  a_open_drain: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    1'b1 |=> (port0_pin_oe_o == ~$past(port0_drive_i)) && port0_pin_o == '0)
    else $error("Open drain drive wrong");
  a_port1_drain: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    1'b1 |=> (port1_pin_oe_o == ~$past(port1_drive_i)) && port1_pin_o == '0)
    else $error("Second port drive wrong");
  a_dac1_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    dac1_wr_i |=> dac1_code_o == $past(dac_code_i))
    else $error("Second DAC code not loaded");
  a_count_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    (rd_req_i && rd_kind_i == RD_COUNT) |=> rd_valid_o && rd_data_o == $past(count_o))
    else $error("Count read wrong");
  // Every request gets exactly one kind of answer in the next cycle
  a_read_answer: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
    rd_req_i |=> rd_valid_o != rd_refused_o)
    else $error("Read answer missing or doubled");
endmodule : gated_totalizer_with_dio
`default_nettype wire

// *** bench/field_model.sv ***
`default_nettype none
module field_model (
  input wire logic [7:0] oe0_i,
  input wire logic [7:0] oe1_i,
  input wire logic [7:0] ext0_i,
  input wire logic [7:0] ext1_i,
  output logic [7:0] pin0_o,
  output logic [7:0] pin1_o,
  output logic pulse_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // =====================================================
  // Pins
  // Pull-ups hold a line high unless some party sinks it
  assign pin0_o = ext0_i & ~oe0_i;
  assign pin1_o = ext1_i & ~oe1_i;
  initial pulse_o = 1'b0;
  // =====================================================
  // Pulse source
  // Fastest legal rate, so any dropped edge shows up
  task automatic send(input int n);
    repeat (n) begin
      #5000 pulse_o = 1'b1;
      #5000 pulse_o = 1'b0;
    end
  endtask : send
endmodule : field_model
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
module testbench
  import totalizer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, resetn = 1'b0, g_hi = 1'b1, g_lo_n = 1'b0, fall = 1'b0;
  logic clr = 1'b0, w0 = 1'b0, w1 = 1'b0, sc0 = 1'b0, sc1 = 1'b0;
  logic req = 1'b0, rem = 1'b0, sel = 1'b0, pulse, vld, refu;
  logic [1:0] kind = 2'h0;
  logic [7:0] drv0 = 8'hFF, drv1 = 8'hFF, ext0 = 8'hA5, ext1 = 8'h3C;
  logic [7:0] pin0, pin1, po0, po1, oe0, oe1;
  logic [15:0] code = 16'h0000, dac0, dac1;
  logic [25:0] rdata, cnt;
  int err_count = 0, checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  field_model fm (.oe0_i(oe0), .oe1_i(oe1), .ext0_i(ext0), .ext1_i(ext1),
    .pin0_o(pin0), .pin1_o(pin1), .pulse_o(pulse));
  gated_totalizer_with_dio dut (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .pulse_i(pulse), .gate_hi_i(g_hi), .gate_lo_n_i(g_lo_n), .port0_pin_i(pin0),
    .port1_pin_i(pin1), .port0_pin_o(po0), .port0_pin_oe_o(oe0), .port1_pin_o(po1),
    .port1_pin_oe_o(oe1), .dac0_code_o(dac0), .dac1_code_o(dac1),
    .count_falling_i(fall), .count_clear_i(clr), .port0_drive_i(drv0),
    .port1_drive_i(drv1), .dac0_wr_i(w0), .dac1_wr_i(w1), .dac_code_i(code),
    .port0_in_scan_i(sc0), .port1_in_scan_i(sc1), .rd_req_i(req),
    .rd_remote_i(rem), .rd_kind_i(kind), .rd_port_sel_i(sel), .rd_valid_o(vld),
    .rd_refused_o(refu), .rd_data_o(rdata), .count_o(cnt));
  task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // Request at one falling edge, answer sampled at the next
  task automatic rd(input logic r, input logic [1:0] k, input logic s,
                    input logic rf, input logic [25:0] d);
    rem = r;
    kind = k;
    sel = s;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    chk("refused", {25'h0, rf}, {25'h0, refu});
    chk("valid", {25'h0, ~rf}, {25'h0, vld});
    if (!rf) chk("rd_data", d, rdata);
    @(negedge sys_clk);
  endtask : rd
  task automatic pulses(input int n, input logic [25:0] e);
    fm.send(n);
    // Let the last edge cross the synchroniser before gates or mode change
    repeat (4) @(negedge sys_clk);
    chk("count", e, cnt);
  endtask : pulses
  task automatic t_count();
    pulses(3, 26'h3);
    g_hi = 1'b0;
    pulses(2, 26'h3);
    g_hi = 1'b1;
    g_lo_n = 1'b1;
    pulses(2, 26'h3);
    g_lo_n = 1'b0;
    fall = 1'b1;
    pulses(2, 26'h5);
    rd(1'b0, RD_COUNT, 1'b0, 1'b0, 26'h5);
    clr = 1'b1;
    repeat (4) @(negedge sys_clk);
    clr = 1'b0;
    chk("count", 26'h0, cnt);
    $display("test count done");
  endtask : t_count
  task automatic t_reads();
    rd(1'b0, RD_PORT, 1'b0, 1'b0, 26'hA5);
    rd(1'b0, RD_PORT, 1'b1, 1'b0, 26'h3C);
    rd(1'b0, RD_WORD, 1'b0, 1'b1, 26'h0);
    rd(1'b1, RD_WORD, 1'b0, 1'b0, 26'h3CA5);
    rd(1'b1, RD_NONE, 1'b0, 1'b1, 26'h0);
    sc0 = 1'b1;
    rd(1'b1, RD_WORD, 1'b0, 1'b1, 26'h0);
    sc1 = 1'b1;
    rd(1'b1, RD_PORT, 1'b1, 1'b0, 26'h3C);
    sc0 = 1'b0;
    rd(1'b1, RD_WORD, 1'b0, 1'b1, 26'h0);
    sc1 = 1'b0;
    $display("test reads done");
  endtask : t_reads
  task automatic t_outs();
    drv0 = 8'h0F;
    drv1 = 8'hF0;
    code = 16'hBEEF;
    w0 = 1'b1;
    @(negedge sys_clk);
    w0 = 1'b0;
    code = 16'h1234;
    w1 = 1'b1;
    @(negedge sys_clk);
    w1 = 1'b0;
    @(negedge sys_clk);
    chk("oe0", 26'hF0, {18'h0, oe0});
    chk("oe1", 26'h0F, {18'h0, oe1});
    chk("pin_o", 26'h0, {10'h0, po1, po0});
    rd(1'b0, RD_PORT, 1'b0, 1'b0, 26'h05);
    rd(1'b0, RD_PORT, 1'b1, 1'b0, 26'h30);
    chk("dac0", 26'hBEEF, {10'h0, dac0});
    chk("dac1", 26'h1234, {10'h0, dac1});
    $display("test outputs done");
  endtask : t_outs
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_count();
    t_reads();
    t_outs();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
